// ===== drsp_pkg.sv
// Constants for the drive run/status poller
package drsp_pkg;
  localparam int          CLK_HZ      = 10_000_000;
  localparam int          TMO_MS      = 500;
  localparam int          GAP_MS      = 10;
  localparam int          TMO_CYC     = TMO_MS * (CLK_HZ / 1000);
  localparam int          GAP_CYC     = GAP_MS * (CLK_HZ / 1000);
  localparam logic [7:0]  FN_WRITE    = 8'h10;
  localparam logic [7:0]  FN_READ     = 8'h03;
  localparam logic [15:0] REG_RUN_CMD = 16'h0001;
  localparam logic [15:0] REG_STATUS  = 16'h002C;
  localparam logic [15:0] WR_COUNT    = 16'h0002;
  localparam logic [15:0] RD_COUNT    = 16'h0001;
  localparam logic [7:0]  WR_BYTES    = 8'h04;
  localparam logic [7:0]  RD_BYTES    = 8'h02;
  localparam logic [15:0] CRC_PRESET  = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'hA001;
  localparam logic [3:0]  WR_TX_LEN   = 4'hD;
  localparam logic [3:0]  RD_TX_LEN   = 4'h8;
  localparam logic [3:0]  WR_RX_LEN   = 4'h8;
  localparam logic [3:0]  RD_RX_LEN   = 4'h7;
  localparam int          STAT_FAULT  = 14;
  typedef enum logic [2:0] {ST_IDLE, ST_GAP, ST_SEND, ST_WAIT, ST_ERR} drsp_state_e;
endpackage

// ===== drsp_poller.sv
// Master framer: write run command and frequency, then poll drive status
// Function
// - Write request: addr, 10h, 0001h, 0002h, count, data, CRC
// - Byte count equals following data bytes
// - CRC covers address through last data byte
// - Two-byte CRC-16, preset FFFFh, reflected
// - No header or terminator characters
// - Status read: addr, 03h, 002Ch, 0001h, CRC
// - Whole bytes; byte count is one byte
// - Address from low byte, sent and checked
// - Run word bit layout, bits 11-15 zero
// - Repeat exchange while enable stays asserted
// - Error or fault stops, error held till reset
// - Half-second step timers, one retry, then error
// - At least 10 ms between requests
`timescale 1ns/1ps
`default_nettype none
module drsp_poller #(
  parameter int TMO_CYCLES = drsp_pkg::TMO_CYC,
  parameter int GAP_CYCLES = drsp_pkg::GAP_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        comm_enable,
  input  wire logic        comm_fault_reset,
  input  wire logic [15:0] slave_addr_word,
  input  wire logic        run,
  input  wire logic        fwd_rev,
  input  wire logic        ext_fault,
  input  wire logic        fault_reset,
  input  wire logic [6:0]  mf_in,
  input  wire logic [15:0] freq_ref,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             comm_error,
  output logic [15:0]      status_word,
  output logic             status_valid
);
  import drsp_pkg::*;

  if (TMO_CYCLES < 2 || TMO_CYCLES > 8_000_000 || GAP_CYCLES < 1 || GAP_CYCLES > 8_000_000) begin : g_chk
    $error("drsp_poller: timer parameter out of range");
  end

  localparam logic [22:0] TMO_LIM = 23'(TMO_CYCLES - 1);
  localparam logic [22:0] GAP_LIM = 23'(GAP_CYCLES - 1);

  // Reflected CRC-16, one byte per call
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  drsp_state_e state_r, state_nxt;
  logic        step_r, step_nxt, retry_r, retry_nxt, err_r, err_nxt, sv_r, sv_nxt, bad_r, bad_nxt;
  logic [3:0]  idx_r, idx_nxt, rxi_r, rxi_nxt;
  logic [15:0] crc_r, crc_nxt, rcrc_r, rcrc_nxt, cmd_r, cmd_nxt, frq_r, frq_nxt;
  logic [15:0] stat_r, stat_nxt, rxw_r, rxw_nxt;
  logic [7:0]  addr_r, addr_nxt, tbyte, ebyte;
  logic [22:0] tmr_r, tmr_nxt;
  logic [3:0]  tx_len, rx_len;
  logic        push, buf_rdy, fail, rx_last, rx_ok;

  // Two-entry transmit buffer; a stalled line stops the framer, never drops a byte
  logic [7:0]  b0_r, b0_nxt, b1_r, b1_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic        pop;
  assign buf_rdy  = (cnt_r != 2'd2);
  assign pop      = tx_ready && (cnt_r != 2'd0);
  assign tx_valid = (cnt_r != 2'd0);
  assign tx_data  = b0_r;

  always_comb begin
    b0_nxt  = b0_r;
    b1_nxt  = b1_r;
    cnt_nxt = cnt_r;
    case ({push, pop})
      2'b10: begin
        if (cnt_r == 2'd0) b0_nxt = tbyte;
        else b1_nxt = tbyte;
        cnt_nxt = cnt_r + 2'd1;
      end
      2'b01: begin
        b0_nxt  = b1_r;
        cnt_nxt = cnt_r - 2'd1;
      end
      2'b11: begin
        if (cnt_r == 2'd1) b0_nxt = tbyte;
        else begin
          b0_nxt = b1_r;
          b1_nxt = tbyte;
        end
      end
      default: ;
    endcase
  end

  // Outgoing byte; no framing characters, address leads, CRC closes
  always_comb begin
    tx_len = step_r ? RD_TX_LEN : WR_TX_LEN;
    tbyte  = 8'h00;
    if (idx_r == tx_len - 4'd2) tbyte = crc_r[7:0];
    else if (idx_r == tx_len - 4'd1) tbyte = crc_r[15:8];
    else begin
      case (idx_r)
        4'd0: tbyte = addr_r;
        4'd1: tbyte = step_r ? FN_READ : FN_WRITE;
        4'd2: tbyte = step_r ? REG_STATUS[15:8] : REG_RUN_CMD[15:8];
        4'd3: tbyte = step_r ? REG_STATUS[7:0] : REG_RUN_CMD[7:0];
        4'd4: tbyte = step_r ? RD_COUNT[15:8] : WR_COUNT[15:8];
        4'd5: tbyte = step_r ? RD_COUNT[7:0] : WR_COUNT[7:0];
        4'd6: tbyte = WR_BYTES;
        4'd7: tbyte = cmd_r[15:8];
        4'd8: tbyte = cmd_r[7:0];
        4'd9: tbyte = frq_r[15:8];
        default: tbyte = frq_r[7:0];
      endcase
    end
  end

  // Expected reply byte; data positions of the read reply are not compared
  always_comb begin
    rx_len = step_r ? RD_RX_LEN : WR_RX_LEN;
    case (rxi_r)
      4'd0:    ebyte = addr_r;
      4'd1:    ebyte = step_r ? FN_READ : FN_WRITE;
      4'd2:    ebyte = step_r ? RD_BYTES : REG_RUN_CMD[15:8];
      4'd3:    ebyte = REG_RUN_CMD[7:0];
      4'd4:    ebyte = WR_COUNT[15:8];
      default: ebyte = WR_COUNT[7:0];
    endcase
  end

  assign push    = (state_r == ST_SEND) && (idx_r < tx_len) && buf_rdy;
  assign rx_last = (state_r == ST_WAIT) && rx_valid && (rxi_r == rx_len - 4'd1);
  // Residue of a frame with its own CRC appended is zero
  assign rx_ok   = !bad_r && (crc_byte(rcrc_r, rx_data) == 16'h0000);
  assign fail    = ((state_r == ST_SEND || state_r == ST_WAIT) && tmr_r >= TMO_LIM) || (rx_last && !rx_ok);

  always_comb begin
    state_nxt = state_r;
    step_nxt  = step_r;
    retry_nxt = retry_r;
    err_nxt   = err_r;
    sv_nxt    = 1'b0;
    bad_nxt   = bad_r;
    idx_nxt   = idx_r;
    rxi_nxt   = rxi_r;
    crc_nxt   = crc_r;
    rcrc_nxt  = rcrc_r;
    cmd_nxt   = cmd_r;
    frq_nxt   = frq_r;
    addr_nxt  = addr_r;
    stat_nxt  = stat_r;
    rxw_nxt   = rxw_r;
    tmr_nxt   = tmr_r + 23'd1;
    case (state_r)
      ST_IDLE: begin
        tmr_nxt = 23'd0;
        if (comm_enable) begin
          step_nxt  = 1'b0;
          retry_nxt = 1'b0;
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        if (!comm_enable && !step_r && !retry_r) state_nxt = ST_IDLE;
        else if (tmr_r >= GAP_LIM) begin
          state_nxt = ST_SEND;
          tmr_nxt   = 23'd0;
          idx_nxt   = 4'd0;
          crc_nxt   = CRC_PRESET;
          addr_nxt  = slave_addr_word[7:0];
          cmd_nxt   = {5'h00, mf_in, fault_reset, ext_fault, fwd_rev, run};
          frq_nxt   = freq_ref;
        end
      end
      ST_SEND: begin
        if (push) begin
          idx_nxt = idx_r + 4'd1;
          if (idx_r < tx_len - 4'd2) crc_nxt = crc_byte(crc_r, tbyte);
        end
        if (idx_r == tx_len && cnt_r == 2'd0) begin
          state_nxt = ST_WAIT;
          tmr_nxt   = 23'd0;
          rxi_nxt   = 4'd0;
          rcrc_nxt  = CRC_PRESET;
          bad_nxt   = 1'b0;
        end
      end
      ST_WAIT: begin
        if (rx_valid) begin
          // Reply start resets the timer; the rest must finish in one more period
          if (rxi_r == 4'd0) tmr_nxt = 23'd0;
          rxi_nxt  = rxi_r + 4'd1;
          rcrc_nxt = crc_byte(rcrc_r, rx_data);
          if (rxi_r < rx_len - 4'd2 && !(step_r && rxi_r > 4'd2) && rx_data != ebyte) bad_nxt = 1'b1;
          if (step_r && rxi_r == 4'd3) rxw_nxt = {rx_data, rxw_r[7:0]};
          if (step_r && rxi_r == 4'd4) rxw_nxt = {rxw_r[15:8], rx_data};
        end
        if (rx_last && rx_ok) begin
          state_nxt = ST_GAP;
          tmr_nxt   = 23'd0;
          retry_nxt = 1'b0;
          step_nxt  = !step_r;
          if (step_r) begin
            stat_nxt = rxw_r;
            sv_nxt   = 1'b1;
            if (rxw_r[STAT_FAULT]) begin
              state_nxt = ST_ERR;
              err_nxt   = 1'b1;
            end
          end
        end
      end
      ST_ERR: begin
        tmr_nxt = 23'd0;
        if (comm_fault_reset) begin
          err_nxt   = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (fail) begin
      tmr_nxt = 23'd0;
      if (retry_r) begin
        state_nxt = ST_ERR;
        err_nxt   = 1'b1;
      end else begin
        retry_nxt = 1'b1;
        state_nxt = ST_GAP;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      step_r  <= 1'b0;
      retry_r <= 1'b0;
      err_r   <= 1'b0;
      sv_r    <= 1'b0;
      bad_r   <= 1'b0;
      idx_r   <= 4'd0;
      rxi_r   <= 4'd0;
      crc_r   <= CRC_PRESET;
      rcrc_r  <= CRC_PRESET;
      cmd_r   <= 16'h0000;
      frq_r   <= 16'h0000;
      addr_r  <= 8'h00;
      stat_r  <= 16'h0000;
      rxw_r   <= 16'h0000;
      tmr_r   <= 23'd0;
      b0_r    <= 8'h00;
      b1_r    <= 8'h00;
      cnt_r   <= 2'd0;
    end else begin
      state_r <= state_nxt;
      step_r  <= step_nxt;
      retry_r <= retry_nxt;
      err_r   <= err_nxt;
      sv_r    <= sv_nxt;
      bad_r   <= bad_nxt;
      idx_r   <= idx_nxt;
      rxi_r   <= rxi_nxt;
      crc_r   <= crc_nxt;
      rcrc_r  <= rcrc_nxt;
      cmd_r   <= cmd_nxt;
      frq_r   <= frq_nxt;
      addr_r  <= addr_nxt;
      stat_r  <= stat_nxt;
      rxw_r   <= rxw_nxt;
      tmr_r   <= tmr_nxt;
      b0_r    <= b0_nxt;
      b1_r    <= b1_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign comm_error   = err_r;
  assign status_word  = stat_r;
  assign status_valid = sv_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_push_at(logic s, logic [3:0] i);
    push && step_r == s && idx_r == i;
  endsequence
  sequence s_first_fail;
    fail && !retry_r;
  endsequence

  property p_addr_first;
    s_push_at(1'b0, 4'd0) or s_push_at(1'b1, 4'd0) |-> tbyte == slave_addr_word[7:0] || tbyte == addr_r;
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("first byte is not the slave address");
  property p_wr_func;
    s_push_at(1'b0, 4'd1) |-> tbyte == 8'h10;
  endproperty
  a_wr_func: assert property (p_wr_func) else $error("write function byte wrong");
  property p_rd_reg;
    s_push_at(1'b1, 4'd3) |-> tbyte == 8'h2C;
  endproperty
  a_rd_reg: assert property (p_rd_reg) else $error("status register low byte wrong");
  property p_count;
    s_push_at(1'b0, 4'd6) |-> tbyte == 8'h04;
  endproperty
  a_count: assert property (p_count) else $error("byte count wrong");
  property p_run_hi;
    s_push_at(1'b0, 4'd7) |-> tbyte[7:3] == 5'h00 && tbyte[2:0] == cmd_r[10:8];
  endproperty
  a_run_hi: assert property (p_run_hi) else $error("run word upper bits wrong");
  property p_crc_lo;
    (s_push_at(1'b1, 4'd6) |-> tbyte == crc_r[7:0]) and (s_push_at(1'b1, 4'd7) |-> tbyte == crc_r[15:8]);
  endproperty
  a_crc_lo: assert property (p_crc_lo) else $error("CRC bytes out of order");
  property p_err_hold;
    err_r && !comm_fault_reset |=> err_r && state_r == ST_ERR;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped without reset");
  property p_no_tx_err;
    state_r == ST_ERR |-> !push [*2];
  endproperty
  a_no_tx_err: assert property (p_no_tx_err) else $error("transmit while stopped");
  property p_retry;
    s_first_fail |=> state_r == ST_GAP && retry_r && !err_r;
  endproperty
  a_retry: assert property (p_retry) else $error("first overrun did not retry");
  property p_gap;
    state_r == ST_GAP && $past(state_r) != ST_GAP |-> state_r != ST_SEND [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("request sent without wait");
endmodule
`default_nettype wire

// ===== drsp_slave.sv
// Behavioural drive slave answering write and status-read frames
`timescale 1ns/1ps
`default_nettype none
module drsp_slave (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  input  wire logic [7:0]  addr,
  input  wire logic        stall,
  input  wire logic        mute,
  input  wire logic        bad_crc,
  input  wire logic [15:0] status_in,
  output logic [15:0]      run_q,
  output logic [15:0]      frq_q,
  output int               good_n,
  output int               bad_n
);
  localparam int timeout_detect_select = 1;
  logic [7:0] fb[$];
  logic [7:0] rq[$];
  int         tick = 0;
  int         idle = 0;

  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Whole frame checked by zero residue, then the reply is queued
  task automatic answer();
    logic        wr;
    logic [15:0] c;
    wr = (fb[1] == 8'h10);
    // A new request replaces any reply still held back
    rq.delete();
    if (crc(fb) == 16'h0000 && fb[0] == addr &&
        {fb[2], fb[3], fb[4], fb[5]} == (wr ? 32'h00010002 : 32'h002C0001) &&
        (!wr || fb[6] == 8'h04)) begin
      good_n <= good_n + 1;
      if (wr) begin
        run_q <= {fb[7], fb[8]};
        frq_q <= {fb[9], fb[10]};
        for (int i = 0; i < 6; i++) begin
          rq.push_back(fb[i]);
        end
      end else begin
        rq.push_back(fb[0]);
        rq.push_back(8'h03);
        rq.push_back(8'h02);
        rq.push_back(status_in[15:8]);
        rq.push_back(status_in[7:0]);
      end
      c = crc(rq);
      rq.push_back(c[7:0] ^ {7'h00, bad_crc});
      rq.push_back(c[15:8]);
    end else begin
      bad_n <= bad_n + 1;
    end
    fb.delete();
  endtask

  always @(posedge clk) begin
    tick <= tick + 1;
    tx_ready <= !stall || tick[1];
    if (rst_n && !(tx_valid && tx_ready) && !mute && rq.size() != 0 && tick % (stall ? 9 : 3) == 0) begin
      rx_data <= rq.pop_front();
      rx_valid <= 1'b1;
      idle <= 0;
    end else begin
      // Idle line keeps changing so a stale byte is never mistaken
      rx_data <= rst_n ? ~rx_data : 8'hFF;
      rx_valid <= 1'b0;
      idle <= idle + 1;
    end
    if (!rst_n) begin
      fb.delete();
      rq.delete();
      good_n <= 0;
      bad_n <= 0;
      run_q <= 16'h0000;
      frq_q <= 16'h0000;
    end else if (tx_valid && tx_ready) begin
      if (fb.size() == 0 && idle < 4) begin
        bad_n <= bad_n + 1;
      end
      fb.push_back(tx_data);
      if ((fb.size() == 13 && fb[1] == 8'h10) || (fb.size() == 8 && fb[1] == 8'h03)) begin
        answer();
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the drive run/status poller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import drsp_pkg::*;
  typedef struct {
    logic [15:0] aw;
    logic [3:0]  ctl;
    logic [6:0]  mf;
    logic [15:0] frq;
    logic [15:0] st;
    logic        stl;
    logic [15:0] run_exp;
  } drsp_row_s;
  drsp_row_s rows[4] = '{
    '{16'hA501, 4'h1, 7'h00, 16'h1770, 16'h0041, 1'b0, 16'h0001},
    '{16'h3C07, 4'hA, 7'h7F, 16'hFFFF, 16'hBFFF, 1'b1, 16'h07FA},
    '{16'h00FE, 4'h5, 7'h55, 16'h0000, 16'h8000, 1'b0, 16'h0555},
    '{16'hFF00, 4'hF, 7'h2A, 16'h8001, 16'h0000, 1'b1, 16'h02AF}};
  logic        clk = 0;
  logic        rst_n = 0;
  logic        comm_enable = 0;
  logic        comm_fault_reset = 0;
  logic [15:0] slave_addr_word = 16'h0000;
  logic        run = 0;
  logic        fwd_rev = 0;
  logic        ext_fault = 0;
  logic        fault_reset = 0;
  logic [6:0]  mf_in = 7'h00;
  logic [15:0] freq_ref = 16'h0000;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        comm_error;
  logic [15:0] status_word;
  logic        status_valid;
  logic        stall = 0;
  logic        bad = 0;
  logic        mute = 0;
  logic [15:0] st_in = 16'h0000;
  logic [15:0] run_q;
  logic [15:0] frq_q;
  int          good_n;
  int          bad_n;
  int          fail_count = 0;
  int          check_count = 0;
  int          g0;
  bit          seen;

  // Short counts keep the run brief
  drsp_poller #(.TMO_CYCLES(200), .GAP_CYCLES(4)) dut (
    .clk(clk), .rst_n(rst_n), .comm_enable(comm_enable), .comm_fault_reset(comm_fault_reset),
    .slave_addr_word(slave_addr_word), .run(run), .fwd_rev(fwd_rev), .ext_fault(ext_fault),
    .fault_reset(fault_reset), .mf_in(mf_in), .freq_ref(freq_ref), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .comm_error(comm_error), .status_word(status_word), .status_valid(status_valid));
  drsp_slave slv (
    .clk(clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .addr(slave_addr_word[7:0]), .stall(stall),
    .mute(mute), .bad_crc(bad), .status_in(st_in), .run_q(run_q), .frq_q(frq_q), .good_n(good_n),
    .bad_n(bad_n));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_for(input bit on_err, output bit hit);
    hit = 0;
    for (int i = 0; i < 3000 && !hit; i++) begin
      step(1);
      hit = on_err ? (comm_error === 1'b1) : (status_valid === 1'b1);
    end
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    fail_count++;
    give_verdict();
  end

  initial begin
    step(12);
    rst_n = 1;
    foreach (rows[i]) begin
      slave_addr_word = rows[i].aw;
      {fault_reset, ext_fault, fwd_rev, run} = rows[i].ctl;
      mf_in = rows[i].mf;
      freq_ref = rows[i].frq;
      st_in = rows[i].st;
      stall = rows[i].stl;
      comm_enable = 1;
      wait_for(1'b0, seen);
      chk("status_valid", 16'h0001, {15'h0, seen});
      chk("run word", rows[i].run_exp, run_q);
      chk("freq", rows[i].frq, frq_q);
      chk("status", rows[i].st, status_word);
      chk("bad frames", 16'h0000, bad_n[15:0]);
      comm_enable = 0;
      step(40);
      chk("idle", 16'h0000, {15'h0, tx_valid});
    end
    // Mid-frame reset
    comm_enable = 1;
    step(30);
    rst_n = 0;
    comm_enable = 0;
    step(12);
    chk("reset out", 16'h0000, {tx_valid, comm_error, status_valid, status_word[12:0]});
    rst_n = 1;
    // Corrupt reply: one retry, then latched error
    bad = 1;
    comm_enable = 1;
    wait_for(1'b1, seen);
    chk("error", 16'h0001, {15'h0, seen});
    chk("retries", 16'h0002, good_n[15:0]);
    g0 = good_n;
    step(300);
    chk("halted", g0[15:0], good_n[15:0]);
    chk("held", 16'h0001, {15'h0, comm_error});
    bad = 0;
    comm_fault_reset = 1;
    step(1);
    comm_fault_reset = 0;
    step(2);
    chk("cleared", 16'h0000, {15'h0, comm_error});
    wait_for(1'b0, seen);
    chk("resumed", 16'h0001, {15'h0, seen});
    // Drive reports fault in its status
    st_in = 16'h4000;
    wait_for(1'b1, seen);
    chk("fault", 16'h0001, {15'h0, seen});
    chk("fault status", 16'h4000, status_word);
    // Silent drive: two overruns latch the error
    mute = 1;
    g0 = good_n;
    comm_fault_reset = 1;
    step(1);
    comm_fault_reset = 0;
    wait_for(1'b1, seen);
    chk("timeout error", 16'h0001, {15'h0, seen});
    g0 = good_n - g0;
    chk("timeout retries", 16'h0002, g0[15:0]);
    chk("bad frames end", 16'h0000, bad_n[15:0]);
    give_verdict();
  end
endmodule
`default_nettype wire
